/* hw/tseg_channel.sv */
// One capture/compare channel's reaction to a forced event.
// Assumes the counter value comes from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module tseg_channel
(
  input  wire logic                        clk,
  input  wire logic                        rstN,
  input  wire tseg_pkg::tseg_chan_cfg_t    cfg,
  input  wire logic                        forceEv,
  input  wire logic [tseg_pkg::CNT_W-1:0]  cntValue,
  input  wire logic                        clrFlag,
  input  wire logic                        clrOver,
  output logic                             flagQ,
  output logic                             overQ,
  output logic [tseg_pkg::CNT_W-1:0]       capQ,
  output logic                             irqQ,
  output logic                             dmaQ
);

  logic                       flag_reg;
  logic                       flag_next;
  logic                       over_reg;
  logic                       over_next;
  logic [tseg_pkg::CNT_W-1:0] cap_reg;
  logic [tseg_pkg::CNT_W-1:0] cap_next;
  logic                       irq_reg;
  logic                       irq_next;
  logic                       dma_reg;
  logic                       dma_next;

  // Flags clear on request, but a forced event in the same cycle wins.
  always_comb
  begin
    flag_next = flag_reg & ~clrFlag;
    over_next = over_reg & ~clrOver;
    cap_next  = cap_reg;
    irq_next  = 1'b0;
    dma_next  = 1'b0;
    if (forceEv)
    begin
      flag_next = 1'b1; // R7 R8
      irq_next  = cfg.irqEn; // R7 R8
      dma_next  = cfg.dmaEn; // R7 R8
      if (cfg.isInput)
      begin
        cap_next = cntValue; // R8
        if (flag_reg)
        begin
          over_next = 1'b1; // R9
        end
      end
    end
  end

  // Channel state registers.
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      flag_reg <= 1'b0;
      over_reg <= 1'b0;
      cap_reg  <= 16'h0000;
      irq_reg  <= 1'b0;
      dma_reg  <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
      over_reg <= over_next;
      cap_reg  <= cap_next;
      irq_reg  <= irq_next;
      dma_reg  <= dma_next;
    end
  end

  assign flagQ = flag_reg;
  assign overQ = over_reg;
  assign capQ  = cap_reg;
  assign irqQ  = irq_reg;
  assign dmaQ  = dma_reg;

endmodule
`default_nettype wire

/* hw/tseg_event_gen.sv */
// Software event generation for a general-purpose timer.
// Assumes the counter, auto-reload value and direction come from timer logic
// on ref_clk; the counter and prescaler act on the pulses driven out here.
//
// Overview of operation
// R1 - Writing one to force_update_bit reinitialises the counter and issues an update.
// R2 - The update command bit is set by software and cleared by hardware.
// R3 - Every update clears the prescaler count; its division factor is untouched.
// R4 - Counting down, a forced update loads the counter with the auto-reload value.
// R5 - Counting up or centre-aligned, a forced update clears the counter; the code has no centre-aligned input and clears it only while countDown is low.
// R6 - Channel 1 event bit forces a channel 1 event, then self-clears.
// R7 - Output channel: event sets match flag, plus irq and DMA when enabled.
// R8 - Input channel: event captures counter, sets flag, irq and DMA when enabled.
// R9 - Input capture with flag already set also sets the overcapture flag.
// R10 - Channel 2 to 4 event bits behave like channel 1 for their channels.
// R11 - Writing one to force_trigger_bit makes a trigger event, then self-clears.
// R12 - Forced update acts only when update_disable and update_source_select are zero.
// R13 - A trigger event sets trigger_event_flag; only software clears it.
// R14 - Zero writes, reserved bits ignored; event register always reads zero.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module tseg_event_gen
#(
  parameter int NUM_CH = tseg_pkg::NUM_CH
)
(
  input  wire logic                         ref_clk,
  input  wire logic                         nrst,
  input  wire logic [tseg_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [tseg_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  output logic      [tseg_pkg::DATA_W-1:0]  regRdata,
  input  wire logic [tseg_pkg::CNT_W-1:0]   cntValue,
  input  wire logic [tseg_pkg::CNT_W-1:0]   autoReload,
  input  wire logic                         countDown,
  output logic                              updEvent,
  output logic                              pscClear,
  output tseg_pkg::tseg_cnt_load_t          cntLoad,
  output logic                              trgEvent,
  output logic      [NUM_CH-1:0]            chIrq,
  output logic      [NUM_CH-1:0]            chDma
);

  // Reset release through two flip-flops.
  logic rstSync1_reg;
  logic rstN;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstSync1_reg <= 1'b0;
      rstN         <= 1'b0;
    end
    else
    begin
      rstSync1_reg <= 1'b1;
      rstN         <= rstSync1_reg;
    end
  end

  // Register state.
  logic [1:0]                   ctrl_reg;
  logic [1:0]                   ctrl_next;
  logic [15:0]                  chcfg_reg;
  logic [15:0]                  chcfg_next;
  logic [15:0]                  evgen_reg;
  logic [15:0]                  evgen_next;
  logic                         trgFlag_reg;
  logic                         trgFlag_next;
  logic [tseg_pkg::DATA_W-1:0]  rdata_reg;
  logic [tseg_pkg::DATA_W-1:0]  rdata_next;
  logic                         upd_reg;
  logic                         upd_next;
  logic                         trg_reg;
  logic                         trg_next;
  tseg_pkg::tseg_cnt_load_t     load_reg;
  tseg_pkg::tseg_cnt_load_t     load_next;

  // Decoded strobes.
  logic                         wrCtrl;
  logic                         wrSts;
  logic                         wrEvgen;
  logic                         wrChcfg;
  logic                         updAllowed;

  // Channel wiring.
  logic [NUM_CH-1:0]            chFlag;
  logic [NUM_CH-1:0]            chOver;
  logic [tseg_pkg::CNT_W-1:0]   chCap [NUM_CH];
  logic [NUM_CH-1:0]            chClrFlag;
  logic [NUM_CH-1:0]            chClrOver;

  // Address decode for writes.
  assign wrCtrl  = regWr && (regAddr == tseg_pkg::OFS_CTRL);
  assign wrSts   = regWr && (regAddr == tseg_pkg::OFS_STS);
  assign wrEvgen = regWr && (regAddr == tseg_pkg::OFS_EVGEN);
  assign wrChcfg = regWr && (regAddr == tseg_pkg::OFS_CHCFG);

  // A forced update only counts while updates are enabled and any source may update.
  assign updAllowed = ~ctrl_reg[tseg_pkg::CTRL_UPD_DIS_BIT]
                    & ~ctrl_reg[tseg_pkg::CTRL_UPD_SRC_BIT]; // R12

  // Configuration registers written by software.
  always_comb
  begin
    ctrl_next  = ctrl_reg;
    chcfg_next = chcfg_reg;
    if (wrCtrl)
    begin
      ctrl_next = regWdata[1:0];
    end
    if (wrChcfg)
    begin
      chcfg_next = regWdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl_reg  <= tseg_pkg::CTRL_RST;
      chcfg_reg <= tseg_pkg::CHCFG_RST;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      chcfg_reg <= chcfg_next;
    end
  end

  // Command bits: a one written is held for one cycle, then hardware clears it.
  // Zero bits and reserved bits are dropped, so nothing else is ever stored.
  always_comb
  begin
    evgen_next = tseg_pkg::EVGEN_RST; // R2
    if (wrEvgen)
    begin
      evgen_next[tseg_pkg::EV_UPD_BIT] = regWdata[tseg_pkg::EV_UPD_BIT]; // R1 R14
      evgen_next[tseg_pkg::EV_CH_LSB +: 4] = regWdata[tseg_pkg::EV_CH_LSB +: 4]; // R6 R10 R14
      evgen_next[tseg_pkg::EV_TRG_BIT] = regWdata[tseg_pkg::EV_TRG_BIT]; // R11 R14
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      evgen_reg <= tseg_pkg::EVGEN_RST;
    end
    else
    begin
      evgen_reg <= evgen_next;
    end
  end

  // Update and trigger actions taken from the held command bits.
  always_comb
  begin
    upd_next        = 1'b0;
    trg_next        = evgen_reg[tseg_pkg::EV_TRG_BIT]; // R11
    load_next.load  = 1'b0;
    load_next.value = load_reg.value;
    trgFlag_next    = trgFlag_reg;
    if (wrSts && !regWdata[tseg_pkg::STS_TRG_BIT])
    begin
      trgFlag_next = 1'b0;
    end
    if (evgen_reg[tseg_pkg::EV_TRG_BIT])
    begin
      trgFlag_next = 1'b1; // R13
    end
    if (evgen_reg[tseg_pkg::EV_UPD_BIT] && updAllowed)
    begin
      upd_next       = 1'b1; // R1
      load_next.load = 1'b1; // R1
      if (countDown)
      begin
        load_next.value = autoReload; // R4
      end
      else
      begin
        load_next.value = 16'h0000; // R5
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      upd_reg     <= 1'b0;
      trg_reg     <= 1'b0;
      load_reg    <= '0;
      trgFlag_reg <= 1'b0;
    end
    else
    begin
      upd_reg     <= upd_next;
      trg_reg     <= trg_next;
      load_reg    <= load_next;
      trgFlag_reg <= trgFlag_next;
    end
  end

  // Each update clears the prescaler count only; its factor lives elsewhere.
  assign updEvent = upd_reg;
  assign pscClear = upd_reg; // R3
  assign cntLoad  = load_reg;
  assign trgEvent = trg_reg;

  // One channel instance per capture/compare channel.
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : gen_ch
      tseg_pkg::tseg_chan_cfg_t cfg;

      assign cfg.isInput = chcfg_reg[ch*tseg_pkg::CFG_STRIDE + tseg_pkg::CFG_IN_BIT];
      assign cfg.irqEn   = chcfg_reg[ch*tseg_pkg::CFG_STRIDE + tseg_pkg::CFG_IRQ_BIT];
      assign cfg.dmaEn   = chcfg_reg[ch*tseg_pkg::CFG_STRIDE + tseg_pkg::CFG_DMA_BIT];
      // Status flags clear when software writes zero to them.
      assign chClrFlag[ch] = wrSts && !regWdata[tseg_pkg::STS_CH_LSB + ch];
      assign chClrOver[ch] = wrSts && !regWdata[tseg_pkg::STS_OVR_LSB + ch];

      tseg_channel u_chan
      (
        .clk      (ref_clk),
        .rstN     (rstN),
        .cfg      (cfg),
        .forceEv  (evgen_reg[tseg_pkg::EV_CH_LSB + ch]), // R6 R10
        .cntValue (cntValue),
        .clrFlag  (chClrFlag[ch]),
        .clrOver  (chClrOver[ch]),
        .flagQ    (chFlag[ch]),
        .overQ    (chOver[ch]),
        .capQ     (chCap[ch]),
        .irqQ     (chIrq[ch]),
        .dmaQ     (chDma[ch])
      );
    end
  endgenerate

  // Read mux; data appear in the cycle after the read strobe.
  always_comb
  begin
    rdata_next = '0;
    if (regRd)
    begin
      case (regAddr)
        tseg_pkg::OFS_CTRL:
        begin
          rdata_next[1:0] = ctrl_reg;
        end
        tseg_pkg::OFS_STS:
        begin
          rdata_next[tseg_pkg::STS_CH_LSB +: 4]  = chFlag;
          rdata_next[tseg_pkg::STS_TRG_BIT]      = trgFlag_reg;
          rdata_next[tseg_pkg::STS_OVR_LSB +: 4] = chOver;
        end
        tseg_pkg::OFS_EVGEN:
        begin
          rdata_next = '0; // R14
        end
        tseg_pkg::OFS_CHCFG:
        begin
          rdata_next[15:0] = chcfg_reg;
        end
        tseg_pkg::OFS_CAP0:
        begin
          rdata_next[15:0] = chCap[0];
        end
        tseg_pkg::OFS_CAP0 + tseg_pkg::OFS_CAP_STEP:
        begin
          rdata_next[15:0] = chCap[1];
        end
        tseg_pkg::OFS_CAP0 + 8'(2 * tseg_pkg::OFS_CAP_STEP):
        begin
          rdata_next[15:0] = chCap[2];
        end
        tseg_pkg::OFS_CAP0 + 8'(3 * tseg_pkg::OFS_CAP_STEP):
        begin
          rdata_next[15:0] = chCap[3];
        end
        default:
        begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rdata_reg <= '0;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign regRdata = rdata_reg;

endmodule
`default_nettype wire

/* hw/tseg_pkg.sv */
// Package for the timer software event generation block.
// Holds register offsets, field positions, reset values and carrier types.
// Assumes a byte-addressed register port with 32-bit data words.
package tseg_pkg;

  // Widths of the register port and of the counter values.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int NUM_CH = 4;

  // Register offsets in bytes.
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STS   = 8'h10;
  localparam logic [7:0] OFS_EVGEN = 8'h14;
  localparam logic [7:0] OFS_CHCFG = 8'h18;
  localparam logic [7:0] OFS_CAP0  = 8'h34;
  localparam logic [7:0] OFS_CAP_STEP = 8'h04;

  // Control register fields.
  localparam int CTRL_UPD_DIS_BIT = 0;
  localparam int CTRL_UPD_SRC_BIT = 1;

  // Event generation register fields.
  localparam int EV_UPD_BIT   = 0;
  localparam int EV_CH_LSB    = 1;
  localparam int EV_TRG_BIT   = 6;

  // Status register fields.
  localparam int STS_CH_LSB   = 1;
  localparam int STS_TRG_BIT  = 6;
  localparam int STS_OVR_LSB  = 9;

  // Channel configuration fields, one nibble per channel.
  localparam int CFG_IN_BIT   = 0;
  localparam int CFG_IRQ_BIT  = 1;
  localparam int CFG_DMA_BIT  = 2;
  localparam int CFG_STRIDE   = 4;

  // Reset values.
  localparam logic [1:0]  CTRL_RST  = 2'h0;
  localparam logic [15:0] CHCFG_RST = 16'h0000;
  localparam logic [15:0] EVGEN_RST = 16'h0000;

  // Per-channel configuration carrier.
  typedef struct packed {
    logic isInput;
    logic irqEn;
    logic dmaEn;
  } tseg_chan_cfg_t;

  // Counter reload command carrier.
  typedef struct packed {
    logic             load;
    logic [CNT_W-1:0] value;
  } tseg_cnt_load_t;

endpackage

/* verif/test_tseg_event_gen.sv */
// Self-checking bench for the timer event generation block.
// Assumes the register port and output pulse timing of tseg_event_gen.
`timescale 1ns/1ns
`default_nettype none
module test_tseg_event_gen;
  logic                     ref_clk, nrst, regWr, regRd, countDown;
  logic [7:0]               regAddr;
  logic [31:0]              regWdata, regRdata;
  logic [15:0]              cntValue, autoReload, lastLoad;
  logic                     updEvent, pscClear, trgEvent;
  logic [3:0]               chIrq, chDma;
  logic [27:0]              outs;
  tseg_pkg::tseg_cnt_load_t cntLoad;
  int                       bad_count, checked;

  tseg_event_gen u_dut (.ref_clk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .cntValue, .autoReload, .countDown, .updEvent, .pscClear, .cntLoad, .trgEvent,
    .chIrq, .chDma);

  // Gathers all event outputs into one word for comparison.
  assign outs = {updEvent, pscClear, cntLoad, trgEvent, chIrq, chDma};

  // Free-running 100 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Compares a seen value with the expected one and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One write cycle, then one idle cycle so strobes never collide.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // One read cycle; the data is looked at in the following cycle only.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    check(regRdata, exp);
    @(posedge ref_clk);
  endtask

  // Checks the pulse two edges after a write, and that it is gone a cycle later.
  task automatic pulse(input logic u, input logic [15:0] v, input logic t,
                       input logic [3:0] irq, input logic [3:0] dma);
    if (u)
      lastLoad = v;
    @(negedge ref_clk);
    check({4'h0, outs}, {4'h0, u, u, u, lastLoad, t, irq, dma});
    @(negedge ref_clk);
    check({4'h0, outs}, {7'h00, lastLoad, 9'h000});
    @(posedge ref_clk);
  endtask

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    give_verdict();
  end

  // Main sequence of scenarios.
  initial
  begin
    nrst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h00000000;
    countDown = 1'b0;
    cntValue = 16'h1234;
    autoReload = 16'hBEEF;
    lastLoad = 16'h0000;
    bad_count = 0;
    checked = 0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(tseg_pkg::OFS_EVGEN, 32'h00000000);
    rd(tseg_pkg::OFS_CTRL, 32'h00000000);
    rd(8'h44, 32'h00000000);
    wr(tseg_pkg::OFS_EVGEN, 32'h00000001);
    pulse(1'b1, 16'h0000, 1'b0, 4'h0, 4'h0);
    countDown <= 1'b1;
    wr(tseg_pkg::OFS_EVGEN, 32'h00000001);
    pulse(1'b1, 16'hBEEF, 1'b0, 4'h0, 4'h0);
    countDown <= 1'b0;
    for (int k = 1; k < 4; k++)
    begin
      wr(tseg_pkg::OFS_CTRL, 32'(k));
      wr(tseg_pkg::OFS_EVGEN, 32'h00000001);
      pulse(1'b0, lastLoad, 1'b0, 4'h0, 4'h0);
    end
    wr(tseg_pkg::OFS_CTRL, 32'h00000000);
    wr(tseg_pkg::OFS_EVGEN, 32'h00000040);
    pulse(1'b0, lastLoad, 1'b1, 4'h0, 4'h0);
    rd(tseg_pkg::OFS_STS, 32'h00000040);
    rd(tseg_pkg::OFS_STS, 32'h00000040);
    wr(tseg_pkg::OFS_STS, 32'h00000000);
    rd(tseg_pkg::OFS_STS, 32'h00000000);
    wr(tseg_pkg::OFS_CHCFG, 32'h00006666);
    for (int i = 0; i < 4; i++)
    begin
      wr(tseg_pkg::OFS_EVGEN, 32'h1 << (i + 1));
      pulse(1'b0, lastLoad, 1'b0, 4'h1 << i, 4'h1 << i);
    end
    rd(tseg_pkg::OFS_STS, 32'h0000001E);
    wr(tseg_pkg::OFS_STS, 32'h00000000);
    // Channel 1 output with both requests, 2 input with irq, 3 input with DMA, 4 output bare.
    wr(tseg_pkg::OFS_CHCFG, 32'h00000536);
    cntValue <= 16'h0A5C;
    wr(tseg_pkg::OFS_EVGEN, 32'h0000001E);
    pulse(1'b0, lastLoad, 1'b0, 4'h3, 4'h5);
    rd(tseg_pkg::OFS_CAP0 + 8'h04, 32'h00000A5C);
    rd(tseg_pkg::OFS_CAP0 + 8'h08, 32'h00000A5C);
    rd(tseg_pkg::OFS_CAP0, 32'h00000000);
    rd(tseg_pkg::OFS_STS, 32'h0000001E);
    cntValue <= 16'h0B00;
    wr(tseg_pkg::OFS_EVGEN, 32'h0000001E);
    pulse(1'b0, lastLoad, 1'b0, 4'h3, 4'h5);
    rd(tseg_pkg::OFS_STS, 32'h00000C1E);
    rd(tseg_pkg::OFS_CAP0 + 8'h04, 32'h00000B00);
    // Ones written to status keep their flags, zeros clear them, overcapture included.
    wr(tseg_pkg::OFS_STS, 32'h00000402);
    rd(tseg_pkg::OFS_STS, 32'h00000402);
    wr(tseg_pkg::OFS_STS, 32'h00000000);
    rd(tseg_pkg::OFS_STS, 32'h00000000);
    wr(tseg_pkg::OFS_EVGEN, 32'h0000FF20);
    pulse(1'b0, lastLoad, 1'b0, 4'h0, 4'h0);
    wr(tseg_pkg::OFS_EVGEN, 32'h0000005F);
    rd(tseg_pkg::OFS_EVGEN, 32'h00000000);
    give_verdict();
  end
endmodule
`default_nettype wire

/* verif/tseg_event_gen_chk.sv */
// Concurrent checks for the timer event generation block.
// Assumes it is bound to tseg_event_gen and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module tseg_event_gen_chk
#(
  parameter int NUM_CH = 4
)
(
  input  wire logic                        ref_clk,
  input  wire logic                        nrst,
  input  wire logic [tseg_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [tseg_pkg::DATA_W-1:0] regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  input  wire logic [tseg_pkg::DATA_W-1:0] regRdata,
  input  wire logic [tseg_pkg::CNT_W-1:0]  cntValue,
  input  wire logic [tseg_pkg::CNT_W-1:0]  autoReload,
  input  wire logic                        countDown,
  input  wire logic                        updEvent,
  input  wire logic                        pscClear,
  input  wire tseg_pkg::tseg_cnt_load_t    cntLoad,
  input  wire logic                        trgEvent,
  input  wire logic [NUM_CH-1:0]           chIrq,
  input  wire logic [NUM_CH-1:0]           chDma
);
  logic [1:0]        ctrlReg, ctrlNext;
  logic [15:0]       cfgReg, cfgNext;
  logic [NUM_CH-1:0] irqVec, dmaVec;
  logic              evWr, updOk, trgOk;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Decodes writes to the event register; an update needs both control bits clear.
  assign evWr  = nrst && regWr && regAddr == tseg_pkg::OFS_EVGEN;
  assign updOk = evWr && regWdata[tseg_pkg::EV_UPD_BIT] && ctrlReg == 2'h0;
  assign trgOk = evWr && regWdata[tseg_pkg::EV_TRG_BIT];

  // Mirrors control and channel setup, and works out the expected requests.
  always_comb
  begin
    ctrlNext = ctrlReg;
    cfgNext  = cfgReg;
    if (regWr && regAddr == tseg_pkg::OFS_CTRL)
      ctrlNext = regWdata[1:0];
    if (regWr && regAddr == tseg_pkg::OFS_CHCFG)
      cfgNext = regWdata[15:0];
    for (int i = 0; i < NUM_CH; i++)
    begin
      irqVec[i] = evWr && regWdata[tseg_pkg::EV_CH_LSB+i]
                  && cfgReg[i*tseg_pkg::CFG_STRIDE+tseg_pkg::CFG_IRQ_BIT];
      dmaVec[i] = evWr && regWdata[tseg_pkg::EV_CH_LSB+i]
                  && cfgReg[i*tseg_pkg::CFG_STRIDE+tseg_pkg::CFG_DMA_BIT];
    end
  end

  // Registers the mirrored setup.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrlReg <= 2'h0;
      cfgReg  <= 16'h0000;
    end
    else
    begin
      ctrlReg <= ctrlNext;
      cfgReg  <= cfgNext;
    end
  end

  upd_fires_a: assert property (updOk |-> ##2 (updEvent && pscClear && cntLoad.load))
    else $error("Forced update gave no update pulse.");
  upd_cause_a: assert property (updEvent |-> $past(updOk, 2))
    else $error("Update pulse without an allowed forced update.");
  psc_tracks_a: assert property (pscClear == updEvent && cntLoad.load == updEvent)
    else $error("Prescaler clear or load differs from update pulse.");
  load_value_a: assert property (cntLoad.load |->
    cntLoad.value == ($past(countDown) ? $past(autoReload) : 16'h0000))
    else $error("Counter load value wrong for count direction.");
  trg_fires_a: assert property (trgOk |-> ##2 trgEvent)
    else $error("Forced trigger gave no trigger pulse.");
  trg_cause_a: assert property (trgEvent |-> $past(trgOk, 2))
    else $error("Trigger pulse without a forced trigger.");
  irq_match_a: assert property (chIrq == $past(irqVec, 2))
    else $error("Channel interrupt requests wrong.");
  dma_match_a: assert property (chDma == $past(dmaVec, 2))
    else $error("Channel DMA requests wrong.");
  evgen_reads_zero_a: assert property (regRd && regAddr == tseg_pkg::OFS_EVGEN |=>
    regRdata == 32'h00000000)
    else $error("Event register read back nonzero.");

  // Main scenarios reached.
  cover property (updEvent && cntLoad.value != 16'h0000);
  cover property (trgEvent);
  cover property (chIrq != 4'h0 && chDma != 4'h0);
  cover property (regRd && regAddr == tseg_pkg::OFS_EVGEN);
endmodule

bind tseg_event_gen tseg_event_gen_chk #(.NUM_CH(NUM_CH)) u_chk (.ref_clk, .nrst, .regAddr,
  .regWdata, .regWr, .regRd, .regRdata, .cntValue, .autoReload, .countDown, .updEvent,
  .pscClear, .cntLoad, .trgEvent, .chIrq, .chDma);
`default_nettype wire
